/* rtl/varh_defs.vh */
// Offsets, field positions, reset values and timing figures of the reactive energy block.
// Assumes a 16-bit register address space with registers at their word offsets.
`ifndef VARH_DEFS_VH
`define VARH_DEFS_VH

// Register offsets
`define OFF_A_TOTAL_VARH   16'hE406
`define OFF_B_TOTAL_VARH   16'hE407
`define OFF_C_TOTAL_VARH   16'hE408
`define OFF_A_FUND_VARH    16'hE409
`define OFF_B_FUND_VARH    16'hE40A
`define OFF_C_FUND_VARH    16'hE40B
`define OFF_IRQ_FLAGS      16'hE502
`define OFF_IRQ_ENABLES    16'hE50A
`define OFF_POWER_SIGN     16'hE617
`define OFF_MEAS_OPTIONS   16'hE700
`define OFF_ACCUM_OPTIONS  16'hE701
`define OFF_LCYC_OPTIONS   16'hE702
`define OFF_PULSE_THRESH   16'hEA03

// Field positions
`define BIT_TOTAL_HALF_FULL 2
`define BIT_FUND_HALF_FULL  3
`define BIT_SIGN_FLIP_A     10
`define BIT_SIGN_FLIP_C     12
`define BIT_Q_SIGN_A        4
`define BIT_Q_SIGN_C        6
`define BIT_SIGN_WATCH_SEL  1
`define BIT_CLEAR_ON_READ   6
`define BIT_WIRING_LO       4
`define BIT_WIRING_HI       5
`define BIT_HALF_MARK       30

// Used status bits: 12..10 and 3..2
`define IRQ_FLAGS_USED     32'h0000_1C0C

// Reset values
`define RST_PULSE_THRESH   8'h03
`define RST_MEAS_OPTIONS   8'h00
`define RST_ACCUM_OPTIONS  8'h00
`define RST_LCYC_OPTIONS   8'h00
`define RST_IRQ_ENABLES    32'h0000_0000

// Wiring codes
`define WIRING_THREE_WIRE  2'b01
`define WIRING_B_NEG_A     2'b11

// Timing: 1.024 MHz accumulation tick from the 40 MHz clock by fractional stepping
`define CLOCK_KHZ          40000
`define ACC_RATE_KHZ       1024
`define TICK_STEP          16'h0400
`define TICK_MODULUS       16'h9C40

// Product scaling: the 49-bit product is cut to 28 bits from this position
`define POWER_SHIFT        21
`endif

/* rtl/reactive_energy_accumulator.v */
// Per-phase reactive energy integration: threshold stage, pulse counters, sign watch, status.
// Assumes voltage and shifted current samples from on-chip logic on the same clock, and a
// register port driven by the serial interface logic on the same clock.
// Register strobes last one cycle and are answered without wait states.
// Powers change only on sample_valid; between samples they are held.

`include "varh_defs.vh"

// One accumulation chain: first-stage threshold integrator and second-stage pulse counter
// Pulses step the count toward the residue's sign, so positive and
// negative power give counts of opposite slope
module var_chain (
    input  wire               clock,
    input  wire               sys_rst,
    input  wire               tick,
    input  wire               clear,
    input  wire signed [27:0] power,
    input  wire        [7:0]  threshold,
    output reg                pulse_q,
    output reg                sign_q,
    output reg                change_q,
    output reg                half_flip_q,
    output reg         [31:0] count_q
);
    // First-stage residue; 40 bits hold the largest threshold plus one
    // full-scale power step with room to spare
    reg signed [39:0] acc_q;
    reg signed [39:0] acc_d;
    reg signed [39:0] sum;
    reg        [31:0] base;
    reg        [31:0] count_d;
    reg               pos;
    reg               neg;
    wire signed [39:0] thr;

    // Threshold sits above 27 zero bits; the top bits stay zero so it is never negative
    assign thr = {5'b0_0000, threshold, 27'h000_0000};

    // First stage: a pulse either way keeps the residue inside one threshold of zero
    always @* begin
        sum     = acc_q + {{12{power[27]}}, power};
        pos     = tick & (sum >= thr);
        neg     = tick & (sum <= -thr);
        // Between ticks the residue is simply held
        acc_d   = acc_q;
        if (tick) begin
            if (pos) begin
                acc_d = sum - thr;
            end else if (neg) begin
                acc_d = sum + thr;
            end else begin
                acc_d = sum;
            end
        end
        // A read-with-reset clears first so a pulse in that same cycle is still counted
        base    = clear ? 32'h0000_0000 : count_q;
        count_d = base;
        // Wrap at either end is plain two's complement arithmetic
        if (pos) begin
            count_d = base + 32'h0000_0001;
        end else if (neg) begin
            count_d = base - 32'h0000_0001;
        end
    end

    // Second stage and sign capture
    always @(posedge clock) begin
        if (sys_rst) begin
            // Zero count, zero residue and a positive sign
            acc_q       <= 40'h00_0000_0000;
            count_q     <= 32'h0000_0000;
            pulse_q     <= 1'b0;
            sign_q      <= 1'b0;
            change_q    <= 1'b0;
            half_flip_q <= 1'b0;
        end else begin
            acc_q       <= acc_d;
            count_q     <= count_d;
            pulse_q     <= pos | neg;
            // A change is judged against the last pulse's sign, so the first
            // negative pulse after reset counts as one
            change_q    <= (pos | neg) & (neg != sign_q);
            // Only counting moves bit 30; a clear to zero is not a half-full event
            half_flip_q <= (pos | neg) & (count_d[`BIT_HALF_MARK] != base[`BIT_HALF_MARK]);
            // The sign holds between pulses; with no power it keeps its last value
            if (pos | neg) begin
                sign_q <= neg;
            end
        end
    end
endmodule

module reactive_energy_accumulator (
    input  wire               clock,
    input  wire               sys_rst,
    input  wire               sample_valid,
    input  wire signed [23:0] v_a,
    input  wire signed [23:0] v_b,
    input  wire signed [23:0] v_c,
    input  wire signed [23:0] i_a,
    input  wire signed [23:0] i_b,
    input  wire signed [23:0] i_c,
    input  wire signed [23:0] fi_a,
    input  wire signed [23:0] fi_b,
    input  wire signed [23:0] fi_c,
    input  wire        [15:0] reg_addr,
    input  wire               reg_wr,
    input  wire               reg_rd,
    input  wire        [31:0] reg_wdata,
    output reg         [31:0] reg_rdata,
    output reg                main_irq_n
);
    // Multiply a voltage by a shifted current and keep 28 bits of the product
    // Dropping the low product bits trades a small truncation bias for a
    // narrow accumulator that still sees every sample
    function signed [27:0] mul;
        input signed [24:0] v;
        input signed [23:0] i;
        reg   signed [48:0] p;
        begin
            p   = v * i;
            mul = p[48:`POWER_SHIFT];
        end
    endfunction

    // Tick generator
    reg         [15:0] frac_q;
    reg                tick_q;
    reg         [16:0] frac_sum;
    // Held powers: total A, B, C then fundamental A, B, C
    reg  signed [27:0] pwr_q [0:5];
    reg  signed [24:0] vb_sel;
    reg                b_zero;
    // Status, enables, sign bits and option registers
    reg         [31:0] irq_flags_q;
    reg         [31:0] irq_flags_d;
    reg         [31:0] irq_enables_q;
    reg         [2:0]  q_sign_q;
    reg         [7:0]  measurement_options_q;
    reg         [7:0]  accumulation_options_q;
    reg         [7:0]  line_cycle_options_q;
    reg         [7:0]  reactive_pulse_threshold_q;
    reg         [31:0] rd_d;
    reg         [2:0]  sign_flip;
    reg         [2:0]  sign_now;
    // Per-chain results, packed by chain index
    wire        [5:0]  sign_w;
    wire        [5:0]  change_w;
    wire        [5:0]  half_w;
    wire        [5:0]  clear_w;
    wire        [191:0] count_bus;
    wire        [1:0]  wiring_select;
    wire               sign_watch_select;
    wire               clear_on_read;

    // Named fields of the option registers
    assign wiring_select     = accumulation_options_q[`BIT_WIRING_HI:`BIT_WIRING_LO];
    assign sign_watch_select = measurement_options_q[`BIT_SIGN_WATCH_SEL];
    assign clear_on_read     = line_cycle_options_q[`BIT_CLEAR_ON_READ];

    // Fractional step gives an average 1.024 MHz tick; spacing jitters by one clock
    // The remainder carries over, so no tick is lost and exactly 1024 ticks
    // fall in every 40000 clocks
    always @(posedge clock) begin
        if (sys_rst) begin
            frac_q <= 16'h0000;
            tick_q <= 1'b0;
        end else if (frac_sum >= {1'b0, `TICK_MODULUS}) begin
            frac_q <= frac_sum[15:0] - `TICK_MODULUS;
            tick_q <= 1'b1;
        end else begin
            frac_q <= frac_sum[15:0];
            tick_q <= 1'b0;
        end
    end

    // Seventeen bits keep the carry for the wrap test
    always @* begin
        frac_sum = {1'b0, frac_q} + {1'b0, `TICK_STEP};
    end

    // Phase B voltage and current follow the wiring code; the reserved code acts as 00
    // The three-wire B voltage is still formed, but the forced-zero product
    // leaves it unused; this keeps the select logic uniform
    always @* begin
        b_zero = (wiring_select == `WIRING_THREE_WIRE);
        if (wiring_select == `WIRING_B_NEG_A) begin
            vb_sel = -{v_a[23], v_a};
        end else if (b_zero) begin
            vb_sel = {v_a[23], v_a} - {v_c[23], v_c};
        end else begin
            vb_sel = {v_b[23], v_b};
        end
    end

    // Powers are held between samples so each is integrated 128 times per sample
    // All six powers take a new sample on one edge, so no chain ever
    // integrates a mix of old and new samples
    always @(posedge clock) begin
        if (sys_rst) begin
            pwr_q[0] <= 28'h000_0000;
            pwr_q[1] <= 28'h000_0000;
            pwr_q[2] <= 28'h000_0000;
            pwr_q[3] <= 28'h000_0000;
            pwr_q[4] <= 28'h000_0000;
            pwr_q[5] <= 28'h000_0000;
        end else if (sample_valid) begin
            pwr_q[0] <= mul({v_a[23], v_a}, i_a);
            pwr_q[1] <= b_zero ? 28'h000_0000 : mul(vb_sel, i_b);
            pwr_q[2] <= mul({v_c[23], v_c}, i_c);
            pwr_q[3] <= mul({v_a[23], v_a}, fi_a);
            pwr_q[4] <= b_zero ? 28'h000_0000 : mul(vb_sel, fi_b);
            pwr_q[5] <= mul({v_c[23], v_c}, fi_c);
        end
    end

    // Read-with-reset strobes, one per var-hour register
    // Only the register being read clears; the other five keep counting
    assign clear_w[0] = reg_rd & clear_on_read & (reg_addr == `OFF_A_TOTAL_VARH);
    assign clear_w[1] = reg_rd & clear_on_read & (reg_addr == `OFF_B_TOTAL_VARH);
    assign clear_w[2] = reg_rd & clear_on_read & (reg_addr == `OFF_C_TOTAL_VARH);
    assign clear_w[3] = reg_rd & clear_on_read & (reg_addr == `OFF_A_FUND_VARH);
    assign clear_w[4] = reg_rd & clear_on_read & (reg_addr == `OFF_B_FUND_VARH);
    assign clear_w[5] = reg_rd & clear_on_read & (reg_addr == `OFF_C_FUND_VARH);

    // Six chains: total A, B, C then fundamental A, B, C, all on one threshold
    // A threshold write reaches every chain on the same edge
    genvar k;
    generate
        for (k = 0; k < 6; k = k + 1) begin : chain
            var_chain u_chain (
                .clock       (clock),
                .sys_rst     (sys_rst),
                .tick        (tick_q),
                .clear       (clear_w[k]),
                .power       (pwr_q[k]),
                .threshold   (reactive_pulse_threshold_q),
                .pulse_q     (), // Pulses are seen through the counts
                .sign_q      (sign_w[k]),
                .change_q    (change_w[k]),
                .half_flip_q (half_w[k]),
                .count_q     (count_bus[32*k+31:32*k])
            );
        end
    endgenerate

    // Sign watch looks at one power type only
    // Changing the selection raises no flag by itself; the next pulse of the
    // newly watched chain is judged against that chain's own last sign
    always @* begin
        sign_flip = sign_watch_select ? change_w[5:3] : change_w[2:0];
        sign_now  = sign_watch_select ? sign_w[5:3] : sign_w[2:0];
    end

    // Status: clear by writing ones, but a new event in the same cycle wins
    always @* begin
        irq_flags_d = irq_flags_q;
        if (reg_wr && (reg_addr == `OFF_IRQ_FLAGS)) begin
            irq_flags_d = irq_flags_q & ~reg_wdata;
        end
        irq_flags_d[`BIT_SIGN_FLIP_C:`BIT_SIGN_FLIP_A] =
            irq_flags_d[`BIT_SIGN_FLIP_C:`BIT_SIGN_FLIP_A] | sign_flip;
        irq_flags_d[`BIT_TOTAL_HALF_FULL] = irq_flags_d[`BIT_TOTAL_HALF_FULL] | (|half_w[2:0]);
        irq_flags_d[`BIT_FUND_HALF_FULL]  = irq_flags_d[`BIT_FUND_HALF_FULL] | (|half_w[5:3]);
        // Unused status bits stay zero, whatever software writes
        irq_flags_d = irq_flags_d & `IRQ_FLAGS_USED;
    end

    // Flags, sign bits and interrupt pin
    always @(posedge clock) begin
        if (sys_rst) begin
            irq_flags_q <= 32'h0000_0000;
            q_sign_q    <= 3'b000;
            main_irq_n  <= 1'b1;
        end else begin
            irq_flags_q <= irq_flags_d;
            // Per phase, the sign bit moves only in the cycle its flip flag is raised
            q_sign_q    <= (q_sign_q & ~sign_flip) | (sign_now & sign_flip);
            // The pin follows the next flag value, so it falls on the edge a flag sets;
            // a clear overtaken by a new event in that cycle leaves it low
            main_irq_n  <= ~|(irq_flags_d & irq_enables_q);
        end
    end

    // Configuration registers
    always @(posedge clock) begin
        if (sys_rst) begin
            // Interrupts start disabled so a fresh part leaves the pin released
            irq_enables_q              <= `RST_IRQ_ENABLES;
            measurement_options_q      <= `RST_MEAS_OPTIONS;
            accumulation_options_q     <= `RST_ACCUM_OPTIONS;
            line_cycle_options_q       <= `RST_LCYC_OPTIONS;
            reactive_pulse_threshold_q <= `RST_PULSE_THRESH;
        end else if (reg_wr) begin
            case (reg_addr)
                `OFF_IRQ_ENABLES: begin
                    irq_enables_q <= reg_wdata;
                end
                `OFF_MEAS_OPTIONS: begin
                    measurement_options_q <= reg_wdata[7:0];
                end
                `OFF_ACCUM_OPTIONS: begin
                    accumulation_options_q <= reg_wdata[7:0];
                end
                `OFF_LCYC_OPTIONS: begin
                    line_cycle_options_q <= reg_wdata[7:0];
                end
                `OFF_PULSE_THRESH: begin
                    // Zero is stored as written; software must not program it
                    reactive_pulse_threshold_q <= reg_wdata[7:0];
                end
                // Read-only and unmapped offsets land here and change nothing
                default: begin
                    reactive_pulse_threshold_q <= reactive_pulse_threshold_q;
                end
            endcase
        end
    end

    // Read mux; var-hour reads pass the live count, unmapped offsets read zero
    // The only side effect of a read is the clear strobe formed above
    always @* begin
        case (reg_addr)
            `OFF_A_TOTAL_VARH:  rd_d = count_bus[31:0];
            `OFF_B_TOTAL_VARH:  rd_d = count_bus[63:32];
            `OFF_C_TOTAL_VARH:  rd_d = count_bus[95:64];
            `OFF_A_FUND_VARH:   rd_d = count_bus[127:96];
            `OFF_B_FUND_VARH:   rd_d = count_bus[159:128];
            `OFF_C_FUND_VARH:   rd_d = count_bus[191:160];
            `OFF_IRQ_FLAGS:     rd_d = irq_flags_q;
            `OFF_IRQ_ENABLES:   rd_d = irq_enables_q;
            `OFF_POWER_SIGN:    rd_d = {25'h000_0000, q_sign_q, 4'h0};
            `OFF_MEAS_OPTIONS:  rd_d = {24'h00_0000, measurement_options_q};
            `OFF_ACCUM_OPTIONS: rd_d = {24'h00_0000, accumulation_options_q};
            `OFF_LCYC_OPTIONS:  rd_d = {24'h00_0000, line_cycle_options_q};
            `OFF_PULSE_THRESH:  rd_d = {24'h00_0000, reactive_pulse_threshold_q};
            default:            rd_d = 32'h0000_0000;
        endcase
    end

    // Read data is captured on the read strobe and held until the next read
    // Holding it lets a slow serial port shift the word out at its own pace
    always @(posedge clock) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata <= rd_d;
        end
    end
endmodule

/* tb/varh_chk.sv */
// Assertion checker for the reactive energy block: register reads and the interrupt pin.
// Assumes it is bound to the top module and sees only that module's ports.
`include "varh_defs.vh"
module varh_chk (
    input wire        clock,
    input wire        sys_rst,
    input wire [15:0] reg_addr,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [31:0] reg_wdata,
    input wire [31:0] reg_rdata,
    input wire        main_irq_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic [31:0] en_q;
    logic [7:0]  thr_q;
    logic        mapped;
    logic        byte_reg;

    // Shadows of the enables and threshold, so reads can be judged without the bodies
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            en_q  <= `RST_IRQ_ENABLES;
            thr_q <= `RST_PULSE_THRESH;
        end else if (reg_wr) begin
            if (reg_addr == `OFF_IRQ_ENABLES) en_q <= reg_wdata;
            if (reg_addr == `OFF_PULSE_THRESH) thr_q <= reg_wdata[7:0];
        end
    end

    // Address classes; anything outside the map must read as zero
    assign mapped = reg_addr inside {[`OFF_A_TOTAL_VARH:`OFF_C_FUND_VARH], `OFF_IRQ_FLAGS, `OFF_IRQ_ENABLES,
                    `OFF_POWER_SIGN, `OFF_MEAS_OPTIONS, `OFF_ACCUM_OPTIONS, `OFF_LCYC_OPTIONS, `OFF_PULSE_THRESH};
    assign byte_reg = reg_addr inside {`OFF_MEAS_OPTIONS, `OFF_ACCUM_OPTIONS, `OFF_LCYC_OPTIONS};

    sequence s_read(logic [15:0] a);
        reg_rd && reg_addr == a;
    endsequence

    a_reset_quiet: assert property ($fell(sys_rst) |-> main_irq_n && reg_rdata == 32'h0000_0000)
        else $error("outputs not idle after reset");
    a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_thresh_value: assert property (s_read(`OFF_PULSE_THRESH) |=> reg_rdata == {24'h00_0000, $past(thr_q)})
        else $error("threshold read wrong");
    a_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_sign_bits: assert property (s_read(`OFF_POWER_SIGN) |=> (reg_rdata & 32'hFFFF_FF8F) == 32'h0000_0000)
        else $error("sign register has stray bits");
    a_flag_bits: assert property (s_read(`OFF_IRQ_FLAGS) |=> (reg_rdata & ~`IRQ_FLAGS_USED) == 32'h0000_0000)
        else $error("flag register has stray bits");
    a_byte_upper: assert property (reg_rd && byte_reg |=> reg_rdata[31:8] == 24'h00_0000)
        else $error("option register upper bits set");
    a_irq_masked: assert property ((en_q == 32'h0000_0000) [*2] |-> main_irq_n)
        else $error("interrupt low with all enables clear");
    a_irq_cause: assert property ($fell(main_irq_n) |-> en_q != 32'h0000_0000 || $past(en_q) != 32'h0000_0000)
        else $error("interrupt fell without an enable");
endmodule

bind reactive_energy_accumulator varh_chk u_varh_chk (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .main_irq_n(main_irq_n));

/* tb/test_reactive_energy_accumulator.sv */
// Self-checking bench for the reactive energy block: registers, pulse counts, flags, interrupt.
// Assumes the design and varh_defs.vh are compiled with it; the bench drives every port.
`include "varh_defs.vh"
module test_reactive_energy_accumulator;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [23:0] PF = 24'h7F_FFFF; // Near full scale, so pulses come fast
    localparam logic [23:0] NF = 24'h80_0001;
    localparam logic [23:0] Z  = 24'h00_0000;
    logic        clock;
    logic        sys_rst;
    logic        sample_valid;
    logic [23:0] v_a, v_b, v_c, i_a, i_b, i_c, fi_a, fi_b, fi_c;
    logic [15:0] reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_wdata;
    wire  [31:0] reg_rdata;
    wire         main_irq_n;
    logic [31:0] rd;
    int          fail_count;
    int          compares;

    reactive_energy_accumulator DUT (.clock(clock), .sys_rst(sys_rst), .sample_valid(sample_valid),
        .v_a(v_a), .v_b(v_b), .v_c(v_c), .i_a(i_a), .i_b(i_b), .i_c(i_c), .fi_a(fi_a), .fi_b(fi_b),
        .fi_c(fi_c), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .main_irq_n(main_irq_n));

    // 40 MHz clock
    always #12.5 clock = ~clock;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic reg_write(input logic [15:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask

    // Read data is registered, so it is taken just after the edge that retires the strobe
    task automatic reg_read(input logic [15:0] a);
        @(posedge clock);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1 rd = reg_rdata;
    endtask

    // One sample set; the design holds the powers until the next one
    task automatic load(input logic [23:0] va, vb, vc, ia, ib, ic, fa, fb, fc);
        @(posedge clock);
        {v_a, v_b, v_c, i_a, i_b, i_c, fi_a, fi_b, fi_c} <= {va, vb, vc, ia, ib, ic, fa, fb, fc};
        sample_valid <= 1'b1;
        @(posedge clock);
        sample_valid <= 1'b0;
    endtask

    // Reset, then the given threshold; the smallest, one, lets a run of a few thousand cycles show pulses
    task automatic setup(input logic [31:0] thr);
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        reg_write(`OFF_PULSE_THRESH, thr);
    endtask

    task automatic t_reset_values;
        logic [15:0] addrs [8] = '{`OFF_PULSE_THRESH, `OFF_MEAS_OPTIONS, `OFF_ACCUM_OPTIONS, `OFF_LCYC_OPTIONS,
                                   `OFF_IRQ_ENABLES, `OFF_IRQ_FLAGS, `OFF_POWER_SIGN, 16'hE000};
        setup(32'h0000_0003);
        reg_write(`OFF_POWER_SIGN, 32'h0000_0070);
        reg_write(`OFF_A_TOTAL_VARH, 32'h0000_1234);
        for (int k = 0; k < 8; k++) begin
            reg_read(addrs[k]);
            check("reset read", rd, (k == 0) ? 32'h0000_0003 : 32'h0000_0000);
        end
        reg_read(`OFF_A_TOTAL_VARH);
        check("count read only", rd, 32'h0000_0000);
        check("irq idle", 32'(main_irq_n), 32'h0000_0001);
    endtask

    task automatic t_neg_total;
        setup(32'h0000_0001);
        load(PF, Z, Z, NF, Z, Z, Z, Z, Z);
        repeat (1500) @(posedge clock);
        check("irq masked", 32'(main_irq_n), 32'h0000_0001);
        reg_read(`OFF_IRQ_FLAGS);
        check("flags a", rd, 32'h0000_0404);
        reg_read(`OFF_POWER_SIGN);
        check("sign a", rd, 32'h0000_0010);
        reg_read(`OFF_A_TOTAL_VARH);
        check("a count wraps", 32'(rd[31]), 32'h0000_0001);
        reg_write(`OFF_IRQ_ENABLES, 32'h0000_1C0C);
        repeat (3) @(posedge clock);
        check("irq on", 32'(main_irq_n), 32'h0000_0000);
        load(Z, Z, Z, Z, Z, Z, Z, Z, Z);
        repeat (300) @(posedge clock);
        reg_write(`OFF_IRQ_FLAGS, 32'h0000_0404);
        repeat (3) @(posedge clock);
        check("irq off", 32'(main_irq_n), 32'h0000_0001);
        reg_read(`OFF_IRQ_FLAGS);
        check("flags cleared", rd, 32'h0000_0000);
    endtask

    // Total C positive, fundamental C negative: only the watched chain may flag a sign change
    task automatic t_fund_sel;
        setup(32'h0000_0001);
        reg_write(`OFF_MEAS_OPTIONS, 32'h0000_0002);
        load(Z, Z, PF, Z, Z, PF, Z, Z, NF);
        repeat (1500) @(posedge clock);
        reg_read(`OFF_IRQ_FLAGS);
        check("flags c", rd, 32'h0000_1008);
        reg_read(`OFF_POWER_SIGN);
        check("sign c", rd, 32'h0000_0040);
        reg_read(`OFF_C_TOTAL_VARH);
        check("c total up", 32'(!rd[31] && rd != 0), 32'h0000_0001);
        reg_read(`OFF_C_FUND_VARH);
        check("c fund down", 32'(rd[31]), 32'h0000_0001);
        reg_write(`OFF_IRQ_ENABLES, 32'h0000_0008);
        repeat (3) @(posedge clock);
        check("irq half full", 32'(main_irq_n), 32'h0000_0000);
    endtask

    task automatic t_wiring;
        setup(32'h0000_0001);
        reg_write(`OFF_ACCUM_OPTIONS, 32'h0000_0010);
        load(PF, PF, Z, PF, NF, Z, PF, NF, Z);
        repeat (1500) @(posedge clock);
        reg_read(`OFF_B_TOTAL_VARH);
        check("b total three wire", rd, 32'h0000_0000);
        reg_read(`OFF_B_FUND_VARH);
        check("b fund three wire", rd, 32'h0000_0000);
        reg_read(`OFF_A_TOTAL_VARH);
        check("a total up", 32'(!rd[31] && rd != 0), 32'h0000_0001);
        reg_read(`OFF_IRQ_FLAGS);
        check("no flags", rd, 32'h0000_0000);
        reg_write(`OFF_ACCUM_OPTIONS, 32'h0000_0030);
        load(PF, PF, Z, PF, PF, Z, PF, PF, Z);
        repeat (1500) @(posedge clock);
        reg_read(`OFF_IRQ_FLAGS);
        check("flags b", rd, 32'h0000_080C);
        reg_read(`OFF_POWER_SIGN);
        check("sign b", rd, 32'h0000_0020);
    endtask

    // About 25 ticks of near full-scale power at a threshold of one unit: six pulses
    task automatic t_clear_read;
        logic [31:0] n;
        setup(32'h0000_0001);
        load(PF, Z, Z, PF, Z, Z, Z, Z, Z);
        repeat (1000) @(posedge clock);
        load(Z, Z, Z, Z, Z, Z, Z, Z, Z);
        repeat (300) @(posedge clock);
        reg_read(`OFF_A_TOTAL_VARH);
        n = rd;
        check("pulse count", 32'(n >= 5 && n <= 7), 32'h0000_0001);
        reg_read(`OFF_A_TOTAL_VARH);
        check("count kept", rd, n);
        reg_write(`OFF_LCYC_OPTIONS, 32'h0000_0040);
        reg_read(`OFF_A_TOTAL_VARH);
        check("read before clear", rd, n);
        reg_read(`OFF_A_TOTAL_VARH);
        check("cleared by read", rd, 32'h0000_0000);
    endtask

    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Watchdog: the scenarios need about 7700 cycles
    initial begin
        #(60000 * 25);
        fail_count++;
        finish_test();
    end

    initial begin
        clock = 1'b0;
        {sys_rst, sample_valid, reg_wr, reg_rd} = 4'h8;
        {v_a, v_b, v_c, i_a, i_b, i_c, fi_a, fi_b, fi_c} = '0;
        reg_addr = 16'h0000;
        reg_wdata = 32'h0000_0000;
        t_reset_values();
        t_neg_total();
        t_fund_sel();
        t_wiring();
        t_clear_read();
        finish_test();
    end
endmodule
